//--- include/sync_ctrl_pkg.sv
// constants and types for the core synchronization controller
// assumes one core clock and an active-low asynchronous reset
package sync_ctrl_pkg;

  // kinds of synchronizing operation presented by issue logic
  typedef enum logic [3:0] {
    OP_NONE             = 4'h0,
    OP_INSTR_SYNC       = 4'h1,
    OP_SYSTEM_CALL      = 4'h2,
    OP_RETURN_INTR      = 4'h3,
    OP_RETURN_CRIT      = 4'h4,
    OP_RETURN_MCHECK    = 4'h5,
    OP_INTERRUPT        = 4'h6,
    OP_STATE_MOVE       = 4'h7,
    OP_EXT_ENABLE_WRITE = 4'h8,
    OP_EXT_ENABLE_IMM   = 4'h9,
    OP_MEMORY_SYNC      = 4'hA,
    OP_MEMORY_BARRIER   = 4'hB
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT_EXC = 3'b001,
    ST_WAIT_MEM = 3'b010,
    ST_EXEC     = 3'b011
  } sync_state_t;

  localparam int          ADDR_W        = 32;
  localparam int          COUNT_W       = 4;
  localparam logic [31:0] INSTR_BYTES   = 32'h0000_0004;
  localparam logic [31:0] PC_RESET      = 32'h0000_0000;
  localparam logic [3:0]  COUNT_RESET   = 4'h0;
  localparam logic [3:0]  COUNT_MAX     = 4'hF;
  localparam logic [3:0]  COUNT_ONE     = 4'h1;

endpackage

//--- src/access_tracker.sv
// outstanding storage access counter
// assumes issue and performed strobes come from logic on the same clock
`timescale 1ns/10ps
module access_tracker
  import sync_ctrl_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic issue,
  input  wire logic performed,
  output logic      idle,
  output logic      full
);

  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  wire                inc = issue && !performed && (count_q != COUNT_MAX);
  wire                dec = performed && !issue && (count_q != COUNT_RESET);

  assign count_d = inc ? count_q + COUNT_ONE : (dec ? count_q - COUNT_ONE : count_q);
  assign idle    = (count_q == COUNT_RESET);
  assign full    = (count_q == COUNT_MAX);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= COUNT_RESET;
    else
      count_q <= count_d;
  end

endmodule

//--- src/sync_control.sv
// pipeline synchronization controller: context, execution and storage sync
// assumes issue logic holds sync_valid until sync_done, memory acks each access
// Notes on behaviour
// - interrupts except machine check and sync/return/call ops are context sync
// - hold the operation until all older instructions reported exceptions
// - older instructions finish in old context; younger issue is held
// - system call or interrupt waits while a higher interrupt is pending
// - younger instructions are discarded and refetched in the new context
// - context sync alone does not wait for storage accesses
// - pending instruction machine check blocks; data machine check may come later
// - execution sync waits and keeps old context, no refetch
// - state move, enable writes and memory sync are execution sync
// - enable set with pending external/timer exception takes interrupt first
// - memory barrier and memory sync are handled identically
// - older storage accesses performed before younger ones
// - barrier need not stall younger work architecturally
// - memory sync waits for all older accesses performed
// - context sync invalidates instruction and data shadow translations
`timescale 1ns/10ps
module sync_control
  import sync_ctrl_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        sync_valid,
  input  wire sync_ctrl_pkg::op_kind_t     sync_kind,
  input  wire logic [sync_ctrl_pkg::ADDR_W-1:0] sync_pc,
  input  wire logic                        older_exc_reported,
  input  wire logic                        older_complete,
  input  wire logic                        higher_intr_pending,
  input  wire logic                        instr_mcheck_pending,
  input  wire logic                        new_ext_enable,
  input  wire logic                        ext_exc_pending,
  input  wire logic                        mem_issue,
  input  wire logic                        mem_performed,
  output logic                             issue_hold_q,
  output logic                             mem_block_q,
  output logic                             sync_done_q,
  output logic                             flush_q,
  output logic [sync_ctrl_pkg::ADDR_W-1:0] flush_pc_q,
  output logic                             shadow_inval_q,
  output logic                             ext_intr_take_q
);

  sync_state_t        state_q;
  sync_state_t        state_d;
  op_kind_t           kind_q;
  logic [ADDR_W-1:0]  pc_q;
  logic               mem_idle;
  logic               mem_full;

  access_tracker u_tracker (
    .clock     (clock),
    .rst_n     (rst_n),
    .issue     (mem_issue),
    .performed (mem_performed),
    .idle      (mem_idle),
    .full      (mem_full)
  );

  wire is_ctx = (kind_q == OP_INSTR_SYNC) || (kind_q == OP_SYSTEM_CALL) ||
                (kind_q == OP_RETURN_INTR) || (kind_q == OP_RETURN_CRIT) ||
                (kind_q == OP_RETURN_MCHECK) || (kind_q == OP_INTERRUPT);
  wire is_ee_write = (kind_q == OP_STATE_MOVE) || (kind_q == OP_EXT_ENABLE_WRITE) ||
                     (kind_q == OP_EXT_ENABLE_IMM);
  // barrier and sync share one path
  wire is_storage  = (kind_q == OP_MEMORY_SYNC) || (kind_q == OP_MEMORY_BARRIER);
  wire needs_prio  = (kind_q == OP_SYSTEM_CALL) || (kind_q == OP_INTERRUPT);
  // priority gate for call and interrupt
  // instruction machine check must surface first
  wire exc_ok = older_exc_reported && older_complete && !instr_mcheck_pending &&
                !(needs_prio && higher_intr_pending);
  // pending external or timer exception with enable set
  wire take_ee   = is_ee_write && new_ext_enable && ext_exc_pending;
  wire exec_now  = (state_q == ST_EXEC);
  wire flush_d   = exec_now && (is_ctx || take_ee);
  wire [ADDR_W-1:0] next_pc = pc_q + INSTR_BYTES;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (sync_valid)
          state_d = ST_WAIT_EXC;
      ST_WAIT_EXC:
        if (exc_ok)
          state_d = is_storage ? ST_WAIT_MEM : ST_EXEC;
      ST_WAIT_MEM:
        if (mem_idle)
          state_d = ST_EXEC;
      ST_EXEC:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      kind_q  <= OP_NONE;
      pc_q    <= PC_RESET;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE && sync_valid)
      begin
        kind_q <= sync_kind;
        pc_q   <= sync_pc;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      issue_hold_q    <= 1'b0;
      mem_block_q     <= 1'b0;
      sync_done_q     <= 1'b0;
      flush_q         <= 1'b0;
      flush_pc_q      <= PC_RESET;
      shadow_inval_q  <= 1'b0;
      ext_intr_take_q <= 1'b0;
    end
    else
    begin
      // younger issue held while sync runs
      issue_hold_q    <= (state_d != ST_IDLE);
      // younger storage blocked during drain
      // also from the cycle after the tracker saturates; an access issued in the first full cycle is not counted
      mem_block_q     <= (state_d == ST_WAIT_MEM) || mem_full;
      sync_done_q     <= exec_now;
      flush_q         <= flush_d;
      if (flush_d)
        flush_pc_q <= next_pc;
      shadow_inval_q  <= flush_d;
      ext_intr_take_q <= exec_now && take_ee;
    end
  end

  property p_exc_wait;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_WAIT_EXC) && !exc_ok |=> (state_q == ST_WAIT_EXC);
  endproperty
  a_exc_wait: assert property (p_exc_wait) else $error("sync left wait early");

  property p_prio;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_WAIT_EXC) && needs_prio && higher_intr_pending |=> !exec_now;
  endproperty
  a_prio: assert property (p_prio) else $error("call ran under higher interrupt");

  property p_mcheck;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_WAIT_EXC) && instr_mcheck_pending |=> !exec_now;
  endproperty
  a_mcheck: assert property (p_mcheck) else $error("ran over instr mcheck");

  property p_hold;
    @(posedge clock) disable iff (!rst_n)
    (state_q != ST_IDLE) && (state_q != ST_EXEC) |-> issue_hold_q;
  endproperty
  a_hold: assert property (p_hold) else $error("issue not held during sync");

  property p_refetch;
    @(posedge clock) disable iff (!rst_n)
    exec_now && is_ctx |=> flush_q && shadow_inval_q && (flush_pc_q == $past(next_pc));
  endproperty
  a_refetch: assert property (p_refetch) else $error("no refetch after context sync");

  property p_ctx_nomem;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_WAIT_EXC) && exc_ok && !is_storage |=> exec_now;
  endproperty
  a_ctx_nomem: assert property (p_ctx_nomem) else $error("context sync waited");

  property p_drain;
    @(posedge clock) disable iff (!rst_n)
    exec_now && is_storage |-> mem_idle;
  endproperty
  a_drain: assert property (p_drain) else $error("storage sync ran undrained");

  property p_block;
    @(posedge clock) disable iff (!rst_n)
    (state_q == ST_WAIT_MEM) && !mem_idle |=> (state_q == ST_WAIT_MEM) && mem_block_q;
  endproperty
  a_block: assert property (p_block) else $error("barrier released early");

  property p_ee_take;
    @(posedge clock) disable iff (!rst_n)
    exec_now && take_ee |=> ext_intr_take_q && flush_q;
  endproperty
  a_ee_take: assert property (p_ee_take) else $error("enable interrupt not taken");

  property p_exec_noflush;
    @(posedge clock) disable iff (!rst_n)
    exec_now && !is_ctx && !take_ee |=> sync_done_q && !flush_q;
  endproperty
  a_exec_noflush: assert property (p_exec_noflush) else $error("exec sync flushed");

  property p_single;
    @(posedge clock) disable iff (!rst_n)
    sync_done_q |=> !sync_done_q ##1 !sync_done_q;
  endproperty
  a_single: assert property (p_single) else $error("done pulse repeated");

  c_ctx:  cover property (@(posedge clock) disable iff (!rst_n) exec_now && is_ctx);
  c_mem:  cover property (@(posedge clock) disable iff (!rst_n)
                          (state_q == ST_WAIT_MEM) && !mem_idle ##1 exec_now);
  c_ee:   cover property (@(posedge clock) disable iff (!rst_n) ext_intr_take_q);

endmodule

//--- tb/core_synchronization_control_bench.sv
// self-checking bench for the synchronization controller
// assumes the memory model answers every access the bench issues
`timescale 1ns/10ps
module core_synchronization_control_bench;
  import sync_ctrl_pkg::*;
  logic clock, rst_n, sync_valid, older_exc_reported, older_complete;
  logic higher_intr_pending, instr_mcheck_pending, new_ext_enable;
  logic ext_exc_pending, mem_issue, mem_performed, issue_hold_q, mem_block_q;
  logic sync_done_q, flush_q, shadow_inval_q, ext_intr_take_q;
  logic [31:0] sync_pc, flush_pc_q;
  logic [3:0]  latency, left;
  op_kind_t    sync_kind;
  int failures = 0;
  int check_count = 0;

  sync_control i_sync_control (.clock, .rst_n, .sync_valid, .sync_kind, .sync_pc,
    .older_exc_reported, .older_complete, .higher_intr_pending, .instr_mcheck_pending,
    .new_ext_enable, .ext_exc_pending, .mem_issue, .mem_performed, .issue_hold_q,
    .mem_block_q, .sync_done_q, .flush_q, .flush_pc_q, .shadow_inval_q, .ext_intr_take_q);
  mem_model i_mem_model (.clock, .rst_n, .issue(mem_issue), .latency,
    .performed(mem_performed), .left);

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic start(input op_kind_t k, input logic [31:0] pc);
    sync_kind = k;
    sync_pc = pc;
    sync_valid = 1'b1;
  endtask

  // waits for done, returns cycles and flags seen with it
  task automatic finish(output int n, output logic fl, output logic tk);
    n = 0;
    while (n < 100 && sync_done_q !== 1'b1)
    begin
      @(negedge clock);
      n++;
    end
    fl = flush_q;
    tk = ext_intr_take_q;
    chk1(sync_done_q, 1'b1);
    chk1(shadow_inval_q, flush_q);
    if (flush_q === 1'b1)
      chk(flush_pc_q, sync_pc + INSTR_BYTES);
    sync_valid = 1'b0;
    @(negedge clock);
    chk1(sync_done_q | flush_q, 1'b0);
  endtask

  task automatic pulse(input int c);
    repeat (c)
    begin
      mem_issue = 1'b1;
      @(negedge clock);
    end
    mem_issue = 1'b0;
  endtask

  task automatic t_kinds();
    int n;
    logic fl, tk;
    for (int i = 1; i < 12; i++)
    begin
      start(op_kind_t'(i), {24'h0, i[3:0], 4'h0});
      finish(n, fl, tk);
      chk1(fl, i < 7);
      chk1(n >= 3 && n < 100, 1'b1);
    end
  endtask

  task automatic t_gate();
    int n;
    logic fl, tk;
    for (int g = 0; g < 5; g++)
    begin
      start(g == 4 ? OP_INTERRUPT : OP_SYSTEM_CALL, 32'h0000_2000);
      older_exc_reported = g != 0;
      older_complete = g != 1;
      instr_mcheck_pending = g == 2;
      higher_intr_pending = g > 2;
      repeat (10)
      begin
        @(negedge clock);
        chk1(sync_done_q, 1'b0);
        chk1(issue_hold_q, 1'b1);
      end
      {older_exc_reported, older_complete, instr_mcheck_pending, higher_intr_pending} = 4'hC;
      finish(n, fl, tk);
      chk1(n < 8 && fl, 1'b1);
    end
  endtask

  task automatic t_mem();
    int n;
    logic fl, tk;
    latency = 4'h8;
    pulse(3);
    higher_intr_pending = 1'b1;
    start(OP_INSTR_SYNC, 32'h0000_3000);
    finish(n, fl, tk);
    chk1(n < 8 && left !== 4'h0, 1'b1);
    chk1(fl, 1'b1);
    higher_intr_pending = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      pulse(3);
      start(i == 0 ? OP_MEMORY_SYNC : OP_MEMORY_BARRIER, 32'h0000_3100);
      repeat (6) @(negedge clock);
      chk1(mem_block_q, 1'b1);
      finish(n, fl, tk);
      chk1(left === 4'h0 && n < 100, 1'b1);
      chk1(fl, 1'b0);
    end
  endtask

  task automatic t_ee();
    int n;
    logic fl, tk;
    for (int i = 0; i < 6; i++)
    begin
      new_ext_enable = i != 3;
      ext_exc_pending = i < 4;
      start(op_kind_t'(7 + i % 3), 32'h0000_4000);
      finish(n, fl, tk);
      chk1(tk, i < 3);
      chk1(fl, i < 3);
    end
  endtask

  task automatic t_soft();
    int n;
    logic fl, tk;
    latency = 4'h2;
    // store and push, then memory sync
    pulse(2);
    start(OP_MEMORY_SYNC, 32'h0000_5000);
    finish(n, fl, tk);
    chk1(left === 4'h0 && !fl, 1'b1);
    pulse(1);
    start(OP_MEMORY_SYNC, 32'h0000_5004);
    finish(n, fl, tk);
    chk1(left === 4'h0, 1'b1);
    start(OP_INSTR_SYNC, 32'h0000_5008);
    finish(n, fl, tk);
    chk(flush_pc_q, 32'h0000_500C);
    // exec sync ahead of translation write
    start(OP_STATE_MOVE, 32'h0000_5100);
    finish(n, fl, tk);
    chk1(fl, 1'b0);
    // debug control write then instr sync
    start(OP_INSTR_SYNC, 32'h0000_5104);
    finish(n, fl, tk);
    chk(flush_pc_q, 32'h0000_5108);
  endtask

  // reset in the middle of a held operation
  task automatic t_reset();
    int n;
    logic fl, tk;
    older_exc_reported = 1'b0;
    start(OP_INSTR_SYNC, 32'h0000_6000);
    repeat (3) @(negedge clock);
    chk1(issue_hold_q, 1'b1);
    rst_n = 1'b0;
    sync_valid = 1'b0;
    older_exc_reported = 1'b1;
    #1;
    chk1(issue_hold_q, 1'b0);
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk({26'h0, issue_hold_q, mem_block_q, sync_done_q, flush_q, shadow_inval_q,
      ext_intr_take_q}, 32'h0);
    chk(flush_pc_q, 32'h0);
    start(OP_INSTR_SYNC, 32'h0000_6100);
    finish(n, fl, tk);
    chk1(fl, 1'b1);
  endtask

  initial
  begin
    rst_n = 1'b0;
    {sync_valid, higher_intr_pending, instr_mcheck_pending, mem_issue} = 4'h0;
    {new_ext_enable, ext_exc_pending, older_exc_reported, older_complete} = 4'h3;
    sync_kind = OP_NONE;
    sync_pc = 32'h0;
    latency = 4'h2;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk({26'h0, issue_hold_q, mem_block_q, sync_done_q, flush_q, shadow_inval_q,
      ext_intr_take_q}, 32'h0);
    chk(flush_pc_q, 32'h0);
    t_kinds();
    t_gate();
    t_mem();
    t_ee();
    t_soft();
    t_reset();
    give_verdict();
  end

  initial
  begin
    #50000;
    failures++;
    give_verdict();
  end
endmodule

//--- tb/mem_model.sv
// memory subsystem model: performs issued accesses in order, one every latency+1 cycles
// assumes issue strobes come from the bench on the core clock
`timescale 1ns/10ps
module mem_model
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       issue,
  input  wire logic [3:0] latency,
  output logic            performed,
  output logic [3:0]      left
);
  logic [3:0] wait_q;
  wire        fire = (left != 4'h0) && (wait_q == 4'h0);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left <= 4'h0;
      wait_q <= 4'h0;
      performed <= 1'b0;
    end
    else
    begin
      performed <= fire;
      left <= left + {3'h0, issue} - {3'h0, fire};
      wait_q <= (fire || left == 4'h0) ? latency : wait_q - 4'h1;
    end
  end
endmodule
